// [verilog/mcseq_consts.svh]
// Register offsets, field positions, reset values and character codes of the matchcode block.
// Assumes byte addresses on an 8-bit register address port.
`ifndef MCSEQ_CONSTS_SVH
`define MCSEQ_CONSTS_SVH

`define MC_ADDR_SETTINGS   8'h00
`define MC_ADDR_WILDCARD   8'h04
`define MC_ADDR_MASTER_LO  8'h08
`define MC_ADDR_MASTER_HI  8'h0C
`define MC_ADDR_MASTER_LEN 8'h10
`define MC_ADDR_STATUS     8'h14
`define MC_ADDR_MASK       8'h18

`define MC_SET_BITS        4:0
`define MC_SET_RESET       5'h08
`define MC_WILD_RESET      8'h2A
`define MC_LEN_BITS        3:0
`define MC_LEN_RESET       4'h0
`define MC_MAX_LEN         8
`define MC_EVT_BITS        3:0
`define MC_EVT_NONE        4'h0
`define MC_CHAR_ZERO       8'h30
`define MC_CHAR_NINE       8'h39
`define MC_CHAR_ONE        8'h01

`endif

// [verilog/matchcode_pkg.sv]
// Types shared by the matchcode block and its surroundings.
// Assumes symbols of at most eight characters, leftmost character at index 0.
package matchcode_pkg;

    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_EXACT = 2'b01,
        MODE_WILD  = 2'b10,
        MODE_SEQ   = 2'b11
    } mode_t;

    typedef struct packed {
        logic  mism_seq;
        logic  noread_seq;
        logic  descend;
        mode_t mode;
    } settings_t;

    typedef struct packed {
        logic            valid;
        logic            no_read;
        logic [3:0]      len;
        logic [7:0][7:0] chars;
    } symbol_t;

    typedef struct packed {
        logic valid;
        logic match;
        logic mismatch;
        logic sequenced;
    } verdict_t;

    typedef struct packed {
        logic sequenced;
        logic no_read;
        logic mismatch;
        logic match;
    } events_t;

endpackage

// [verilog/matchcode_wildcard_sequencer.sv]
// Matchcode compare and sequencing logic with configurable wildcard character.
// Assumes one decode result per valid cycle from the decoder and a plain register port.
`timescale 1ns/100ps
`include "mcseq_consts.svh"

// Notes on behaviour
// R1 - In wildcard and sequential modes a wildcard character in the master matches any character, all others must match exactly.
// R2 - Trailing wildcards let shorter symbols down to the fixed prefix match, never longer ones.
// R3 - Leading or middle wildcards give no length freedom, so the length must equal the master's.
// R4 - The wildcard is a software-set ASCII code that comes out of reset as the asterisk.
// R5 - In sequential mode with no-read sequencing on, the master advances on a match or no read.
// R6 - With no-read sequencing off a no read leaves the master alone; of a match and a no read, only the match advances it.
// R7 - No-read sequencing is one bit, 0 off and 1 on, and is on after reset.
// R8 - Mismatch sequencing acts only in sequential mode and is ignored otherwise.
// R9 - Mismatch sequencing on advances the master after every decode that is not a no read; it is one bit, reset off.
// R10 - With mismatch sequencing off, a mismatch after a mismatch keeps the master unchanged.
// R11 - With it off, a mismatch right after a match still advances once, so the last verdict is kept.
// R12 - Sequencing sets the master one above or one below the decoded value on a match, or the current master otherwise, by count direction.
// R13 - The direction bit is 0 for ascending and 1 for descending, ascending after reset.
// R14 - Mode code 3 selects sequential matching.
// R15 - Each decode result outside off mode gives one verdict, and in sequential mode its master update, registered at the clock edge after it arrives.
module matchcode_wildcard_sequencer
    import matchcode_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire symbol_t     i_symbol,
    output verdict_t         o_verdict,
    output logic             o_irq
);

    settings_t       settings_q, settings_d;
    logic [7:0]      wild_q, wild_d;
    logic [7:0][7:0] master_q, master_d;
    logic [3:0]      mlen_q, mlen_d;
    logic            prev_match_q, prev_match_d;
    events_t         status_q, status_d;
    events_t         mask_q, mask_d;
    logic [31:0]     rdata_q, rdata_d;
    verdict_t        verdict_q, verdict_d;

    logic            wild_on;
    logic            trail;
    logic [3:0]      plen;
    logic            len_ok;
    logic            chars_ok;
    logic            is_match;
    logic            advance;
    logic            carry;
    logic [7:0][7:0] base;
    logic [7:0][7:0] stepped;
    events_t         events;

    // Compare against the master
    always_comb begin
        wild_on  = (settings_q.mode == MODE_WILD) || (settings_q.mode == MODE_SEQ);
        plen     = mlen_q;
        trail    = 1'b1;
        chars_ok = 1'b1;
        // Only wildcards at the tail shorten the fixed prefix
        for (int i = `MC_MAX_LEN - 1; i >= 0; i--) begin
            if (i < int'(mlen_q)) begin
                if (trail && wild_on && master_q[i] == wild_q) begin
                    plen = 4'(i); // R2
                end else begin
                    trail = 1'b0; // R3
                end
            end
        end
        for (int i = 0; i < `MC_MAX_LEN; i++) begin
            if (i < int'(i_symbol.len)) begin
                if (!(master_q[i] == i_symbol.chars[i] || (wild_on && master_q[i] == wild_q))) begin
                    chars_ok = 1'b0; // R1
                end
            end
        end
        len_ok   = (i_symbol.len == mlen_q) ||
                   (i_symbol.len < mlen_q && i_symbol.len >= plen); // R2 R3
        is_match = len_ok && chars_ok;
    end

    // Decide whether the master moves
    always_comb begin
        advance      = 1'b0;
        prev_match_d = prev_match_q;
        if (i_symbol.valid && settings_q.mode == MODE_SEQ) begin // R14 R8
            if (i_symbol.no_read) begin
                advance = settings_q.noread_seq; // R5 R6
            end else if (is_match) begin
                advance      = 1'b1;
                prev_match_d = 1'b1; // R11
            end else begin
                advance      = settings_q.mism_seq || prev_match_q; // R9 R10 R11
                prev_match_d = 1'b0;
            end
        end
    end

    // Mechanical decimal counter over the master length; rolls over rather than growing.
    // Non-digit characters are stepped as raw codes, so only numeric masters make sense here.
    always_comb begin
        base    = (i_symbol.valid && !i_symbol.no_read && is_match) ? i_symbol.chars : master_q; // R12
        stepped = base;
        carry   = 1'b1;
        for (int i = `MC_MAX_LEN - 1; i >= 0; i--) begin
            if (i < int'(mlen_q) && carry) begin
                if (!settings_q.descend) begin // R13
                    if (base[i] == `MC_CHAR_NINE) begin
                        stepped[i] = `MC_CHAR_ZERO;
                    end else begin
                        stepped[i] = base[i] + `MC_CHAR_ONE; // R12
                        carry      = 1'b0;
                    end
                end else begin
                    if (base[i] == `MC_CHAR_ZERO) begin
                        stepped[i] = `MC_CHAR_NINE;
                    end else begin
                        stepped[i] = base[i] - `MC_CHAR_ONE; // R12
                        carry      = 1'b0;
                    end
                end
            end
        end
    end

    // Verdict, events and register file
    always_comb begin
        settings_d = settings_q;
        wild_d     = wild_q;
        master_d   = master_q;
        mlen_d     = mlen_q;
        mask_d     = mask_q;
        rdata_d    = 32'h0000_0000;
        events     = `MC_EVT_NONE;
        verdict_d  = '0;
        if (i_symbol.valid && settings_q.mode != MODE_OFF) begin // R15
            verdict_d.valid     = 1'b1;
            verdict_d.match     = !i_symbol.no_read && is_match;
            verdict_d.mismatch  = !i_symbol.no_read && !is_match;
            verdict_d.sequenced = advance;
            events.match        = verdict_d.match;
            events.mismatch     = verdict_d.mismatch;
            events.no_read      = i_symbol.no_read;
            events.sequenced    = advance;
        end
        status_d = status_q;
        if (i_wr) begin
            unique case (i_addr)
                `MC_ADDR_SETTINGS:   settings_d = i_wdata[`MC_SET_BITS]; // R7 R9 R13
                `MC_ADDR_WILDCARD:   wild_d = i_wdata[7:0]; // R4
                `MC_ADDR_MASTER_LO:  master_d[3:0] = i_wdata;
                `MC_ADDR_MASTER_HI:  master_d[7:4] = i_wdata;
                `MC_ADDR_MASTER_LEN: mlen_d = i_wdata[`MC_LEN_BITS];
                `MC_ADDR_STATUS:     status_d = status_q & ~i_wdata[`MC_EVT_BITS];
                `MC_ADDR_MASK:       mask_d = i_wdata[`MC_EVT_BITS];
                default:             ;
            endcase
        end
        // A sequencing step outranks a software master write in the same cycle
        if (advance) begin
            master_d = stepped; // R15
        end
        // Set wins over a clear in the same cycle
        status_d = status_d | events;
        if (i_rd) begin
            unique case (i_addr)
                `MC_ADDR_SETTINGS:   rdata_d = 32'(settings_q);
                `MC_ADDR_WILDCARD:   rdata_d = 32'(wild_q);
                `MC_ADDR_MASTER_LO:  rdata_d = master_q[3:0];
                `MC_ADDR_MASTER_HI:  rdata_d = master_q[7:4];
                `MC_ADDR_MASTER_LEN: rdata_d = 32'(mlen_q);
                `MC_ADDR_STATUS:     rdata_d = 32'(status_q);
                `MC_ADDR_MASK:       rdata_d = 32'(mask_q);
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            settings_q   <= `MC_SET_RESET; // R7 R9 R13
            wild_q       <= `MC_WILD_RESET; // R4
            master_q     <= '0;
            mlen_q       <= `MC_LEN_RESET;
            prev_match_q <= 1'b0;
            status_q     <= `MC_EVT_NONE;
            mask_q       <= `MC_EVT_NONE;
            rdata_q      <= 32'h0000_0000;
            verdict_q    <= '0;
        end else begin
            settings_q   <= settings_d;
            wild_q       <= wild_d;
            master_q     <= master_d;
            mlen_q       <= mlen_d;
            prev_match_q <= prev_match_d;
            status_q     <= status_d;
            mask_q       <= mask_d;
            rdata_q      <= rdata_d;
            verdict_q    <= verdict_d;
        end
    end

    assign o_rdata   = rdata_q;
    assign o_verdict = verdict_q;
    assign o_irq     = |(status_q & mask_q);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence seq_decode_s;
        i_symbol.valid && !i_symbol.no_read && settings_q.mode == MODE_SEQ;
    endsequence

    sequence mism_after_match_s;
        seq_decode_s and (prev_match_q && !is_match && !settings_q.mism_seq);
    endsequence

    sequence mism_after_mism_s;
        seq_decode_s and (!prev_match_q && !is_match && !settings_q.mism_seq);
    endsequence

    wild_default_a: assert property ($fell(i_reset) |-> wild_q == `MC_WILD_RESET) // R4
        else $error("wildcard not asterisk after reset");

    noread_step_a: assert property (i_symbol.valid && i_symbol.no_read && // R5
        settings_q.mode == MODE_SEQ && settings_q.noread_seq |=> o_verdict.sequenced)
        else $error("no read did not sequence");

    noread_hold_a: assert property (i_symbol.valid && i_symbol.no_read && // R6
        !settings_q.noread_seq && !i_wr |=> master_q == $past(master_q) && !o_verdict.sequenced)
        else $error("no read moved the master");

    other_mode_a: assert property (i_symbol.valid && settings_q.mode != MODE_SEQ // R8
        |=> !o_verdict.sequenced)
        else $error("sequenced outside sequential mode");

    mism_step_a: assert property (seq_decode_s and settings_q.mism_seq // R9
        |=> o_verdict.sequenced)
        else $error("mismatch sequencing did not step");

    double_mism_a: assert property (mism_after_mism_s |=> !o_verdict.sequenced) // R10
        else $error("second mismatch sequenced");

    match_then_mism_a: assert property (mism_after_match_s // R11
        |=> o_verdict.sequenced && !prev_match_q)
        else $error("mismatch after match did not sequence once");

    longer_symbol_a: assert property (i_symbol.valid && !i_symbol.no_read && // R2
        i_symbol.len > mlen_q && settings_q.mode != MODE_OFF |=> o_verdict.mismatch)
        else $error("longer symbol matched");

    inc_step_a: assert property (seq_decode_s and (is_match && !settings_q.descend && // R12
        mlen_q != 4'h0 && i_symbol.chars[mlen_q - 4'h1] < `MC_CHAR_NINE && !i_wr)
        |=> master_q[mlen_q - 4'h1] == $past(i_symbol.chars[mlen_q - 4'h1]) + `MC_CHAR_ONE)
        else $error("master not one above decoded value");

    one_verdict_a: assert property (i_symbol.valid && settings_q.mode != MODE_OFF // R15
        |=> o_verdict.valid && (o_verdict.match != o_verdict.mismatch || $past(i_symbol.no_read)))
        else $error("decode result without single verdict");

endmodule

// [testbench/symbol_source.sv]
// Decoder front end model: presents one decode result per call of send.
// Assumes the caller runs just after a rising clock edge of i_clk.
`timescale 1ns/100ps
module symbol_source
    import matchcode_pkg::*;
(
    input  wire logic i_clk,
    output symbol_t   o_symbol
);
    initial o_symbol = '0;

    task automatic send(input logic nr, input logic [3:0] len, input logic [63:0] c);
        @(posedge i_clk);
        o_symbol <= '{valid: 1'b1, no_read: nr, len: len, chars: c};
        @(posedge i_clk);
        // Stale fields are inverted so a lingering value never passes for a fresh one
        o_symbol <= '{valid: 1'b0, no_read: ~nr, len: ~len, chars: ~c};
    endtask
endmodule

// [testbench/matchcode_wildcard_sequencer_test.sv]
// Register-port bench for the matchcode block, decode results from symbol_source.
// Assumes one clock at 25 MHz and the register map of mcseq_consts.svh.
`timescale 1ns/100ps
`include "mcseq_consts.svh"
module matchcode_wildcard_sequencer_test
    import matchcode_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [31:0] o_rdata;
    symbol_t     sym;
    verdict_t    o_verdict;
    logic        o_irq;
    int          err_count = 0;
    int          compares = 0;
    logic [31:0] exp_lo = 32'h0;

    always #20 i_clk = ~i_clk;

    symbol_source u_src (.i_clk(i_clk), .o_symbol(sym));
    matchcode_wildcard_sequencer u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_symbol(sym),
        .o_verdict(o_verdict), .o_irq(o_irq));

    function automatic logic [63:0] str2c(input string s);
        logic [63:0] c;
        c = '0;
        for (int i = 0; i < s.len(); i++) c[i*8 +: 8] = s[i];
        return c;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, exp);
    endtask

    task automatic set_master(input string s);
        logic [63:0] c;
        c = str2c(s);
        wr(`MC_ADDR_MASTER_LO, c[31:0]);
        wr(`MC_ADDR_MASTER_HI, c[63:32]);
        wr(`MC_ADDR_MASTER_LEN, 32'(s.len()));
        exp_lo = c[31:0];
    endtask

    // Sends one result, checks {valid, match, mismatch, sequenced}, then the low master word
    // Sequencing is expected exactly when the scenario's next low master word differs from the last one
    task automatic step(input string s, input logic nr, input logic [1:0] mm, input string nxt);
        logic [63:0] c;
        c = str2c(nxt);
        u_src.send(nr, 4'(s.len()), str2c(s));
        #1;
        check({28'h0, o_verdict.valid, o_verdict.match, o_verdict.mismatch,
               o_verdict.sequenced}, {28'h0, 1'b1, mm, c[31:0] != exp_lo});
        exp_lo = c[31:0];
        chk_rd(`MC_ADDR_MASTER_LO, c[31:0]);
    endtask

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        chk_rd(`MC_ADDR_SETTINGS, 32'h08);
        chk_rd(`MC_ADDR_WILDCARD, 32'h2A);
        chk_rd(`MC_ADDR_MASTER_LO, 32'h0);
        chk_rd(8'h1C, 32'h0);
        u_src.send(1'b0, 4'h3, str2c("001"));
        #1;
        check({28'h0, o_verdict}, 32'h0);
        $display("test reset done");
        wr(`MC_ADDR_SETTINGS, 32'h0A);
        set_master("CR*34");
        step("CR134", 1'b0, 2'b10, "CR*34");
        step("CR2345", 1'b0, 2'b01, "CR*34");
        step("CRX35", 1'b0, 2'b01, "CR*34");
        set_master("AB**");
        step("AB", 1'b0, 2'b10, "AB**");
        step("ABC", 1'b0, 2'b10, "AB**");
        step("ABCDE", 1'b0, 2'b01, "AB**");
        set_master("A*C");
        step("AXC", 1'b0, 2'b10, "A*C");
        step("AX", 1'b0, 2'b01, "A*C");
        wr(`MC_ADDR_WILDCARD, 32'h3F);
        step("AXC", 1'b0, 2'b01, "A*C");
        chk_rd(`MC_ADDR_WILDCARD, 32'h3F);
        wr(`MC_ADDR_WILDCARD, 32'h2A);
        wr(`MC_ADDR_SETTINGS, 32'h09);
        step("AXC", 1'b0, 2'b01, "A*C");
        step("A*C", 1'b0, 2'b10, "A*C");
        $display("test wildcard done");
        wr(`MC_ADDR_MASK, 32'h1);
        wr(`MC_ADDR_STATUS, 32'hF);
        check({31'h0, o_irq}, 32'h0);
        wr(`MC_ADDR_SETTINGS, 32'h0B);
        set_master("001");
        step("001", 1'b0, 2'b10, "002");
        check({31'h0, o_irq}, 32'h1);
        wr(`MC_ADDR_STATUS, 32'h1);
        check({31'h0, o_irq}, 32'h0);
        chk_rd(`MC_ADDR_STATUS, 32'h8);
        step("", 1'b1, 2'b00, "003");
        wr(`MC_ADDR_SETTINGS, 32'h03);
        step("", 1'b1, 2'b00, "003");
        step("003", 1'b0, 2'b10, "004");
        step("abc", 1'b0, 2'b01, "005");
        step("def", 1'b0, 2'b01, "005");
        wr(`MC_ADDR_SETTINGS, 32'h13);
        step("ghi", 1'b0, 2'b01, "006");
        wr(`MC_ADDR_SETTINGS, 32'h0F);
        step("006", 1'b0, 2'b10, "005");
        wr(`MC_ADDR_SETTINGS, 32'h12);
        step("xyz", 1'b0, 2'b01, "005");
        $display("test sequence done");
        finish_test();
    end
endmodule
